// ---- rtl/uric_top.sv ----
// Line-mode logic of one serial channel: half-duplex direction, tx interrupt, infrared path
//
// Contract
// - Delay field bits 7:5 sets bit times direction stays high; only in half-duplex.
// - Delay counts only when shift register and FIFO empty; holding write cancels it.
// - Direction rises one bit before first stop bit; stays high while data pending.
// - After both empty, direction holds for 0 to 15 bit times, then drops.
// - Large-block: tx interrupt on threshold crossing, or on empty if not above since the last drain.
// - Half-duplex without large-block: tx interrupt only when shift register empties.
// - Listen enable set: store data, offer threshold, timeout and error interrupts.
// - No loop, no listen, plain mode: store data, no timeout interrupt.
// - No loop, no listen, half-duplex or infrared: nothing stored, no interrupts.
// - Loopback idles the tx pin, not the direction pin; without listen data stored, timeout interrupt withheld.
// - Infrared coder runs on the 16x tick, sixteen ticks per bit.
// - Infrared one is no pulse, zero is one pulse, every bit coded alike.
// - Infrared pulse lasts three 16x ticks at least.
// - Encoder output low and counter cleared while transmit data is high.
// - Encoder raises output on seventh tick, lowers on tenth, every zero bit.
// - Decoder output high and counter cleared after reset.
// - Falling edge drives decoded low at next tick for sixteen ticks.
// - Without falling edges the decoded output stays high.
// - Sample decoded data on eighth tick after start edge, then every sixteen.
// - Decoder accepts positive pulses, taking zero on their trailing edge.
// - Bit 2 enables half-duplex; without large-block, tx interrupts wait for shift register empty.
// - Bit 3 selects large-block; tx interrupts then follow threshold or empty.
// - Bit 1 enables infrared coding on the serial pins.
// - Bit 4 listen enable gates storage only in half-duplex or infrared mode; it gates the timeout interrupt in every mode.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "uric_regs.svh"
module uric_top
  import uric_pkg::*;
#(
  parameter int FRAME_BITS = `URIC_FRAME_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic chan_reset_i,
  // Register port
  input wire uric_bus_req_type bus_i,
  output logic [`URIC_DATA_W-1:0] rdata_o,
  // Transmit core status
  input wire logic baud16_tick_i,
  input wire uric_tx_stat_type tx_stat_i,
  input wire logic tx_serial_i,
  output logic tx_irq_o,
  // Receive core gating
  input wire logic rx_char_valid_i,
  output logic rx_serial_o,
  output logic rx_store_o,
  output logic rx_irq_allow_o,
  output logic rx_timeout_allow_o,
  output logic rx_sample_o,
  output logic rx_sample_bit_o,
  // Pins
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  output logic line_direction_output_o
);
  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin_i;
      rx_sync <= rx_meta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`URIC_DATA_W-1:0] alternate_function_control;
  logic loopback_select_bit;
  logic [2:0] turnoff_delay_bits;
  logic receiver_listen_enable;
  logic large_block_transmit;
  logic half_duplex_line_enable;
  logic infrared_mode_enable;
  uric_dir_state_type dir_state;
  logic [`URIC_DATA_W-1:0] next_rdata;

  assign turnoff_delay_bits = alternate_function_control[`URIC_AFC_DLY_MSB:`URIC_AFC_DLY_LSB];
  assign receiver_listen_enable = alternate_function_control[`URIC_AFC_RCV];
  assign large_block_transmit = alternate_function_control[`URIC_AFC_LG];
  assign half_duplex_line_enable = alternate_function_control[`URIC_AFC_HD];
  assign infrared_mode_enable = alternate_function_control[`URIC_AFC_IR];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alternate_function_control <= `URIC_AFC_RST;
      loopback_select_bit <= `URIC_LOOP_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `URIC_AFC_OFS) begin
        alternate_function_control <= bus_i.wdata & `URIC_AFC_WMASK;
      end
      if (bus_i.addr == `URIC_LOOP_OFS) begin
        loopback_select_bit <= bus_i.wdata[`URIC_LOOP_BIT];
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    case (bus_i.addr)
      `URIC_AFC_OFS: next_rdata = alternate_function_control;
      `URIC_LOOP_OFS: next_rdata[`URIC_LOOP_BIT] = loopback_select_bit;
      `URIC_STAT_OFS: next_rdata = {4'h0, tx_pin_o, rx_serial_o,
                                    dir_state == DIR_HOLD, line_direction_output_o};
      default: next_rdata = '0;
    endcase
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Direction control and turn-off delay
  // ----------------------------------------------------------------
  logic both_empty;
  logic [3:0] hold_tick;
  logic [3:0] hold_left;
  logic [3:0] delay_bits;

  assign both_empty = tx_stat_i.tsr_empty && tx_stat_i.fifo_empty;
  // Three-bit field spread over 0..15 bit times as 2n+1, zero meaning none
  assign delay_bits = (turnoff_delay_bits == 3'h0) ? 4'h0 : {turnoff_delay_bits, 1'b1};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_state <= DIR_IDLE;
      hold_tick <= 4'h0;
      hold_left <= 4'h0;
    end else if (chan_reset_i || !half_duplex_line_enable) begin
      dir_state <= DIR_IDLE;
      hold_tick <= 4'h0;
      hold_left <= 4'h0;
    end else begin
      case (dir_state)
        DIR_IDLE: begin
          if (tx_stat_i.pre_stop) begin
            dir_state <= DIR_SEND;
          end
        end
        DIR_SEND: begin
          if (both_empty && !tx_stat_i.thr_write && !tx_stat_i.pre_stop) begin
            if (delay_bits == 4'h0) begin
              dir_state <= DIR_IDLE;
            end else begin
              dir_state <= DIR_HOLD;
              hold_tick <= 4'h0;
              hold_left <= delay_bits;
            end
          end
        end
        DIR_HOLD: begin
          if (tx_stat_i.thr_write || !both_empty || tx_stat_i.pre_stop) begin
            dir_state <= DIR_SEND;
          end else if (baud16_tick_i) begin
            hold_tick <= hold_tick + 4'h1;
            if (hold_tick == `URIC_BIT_LAST) begin
              hold_left <= hold_left - 4'h1;
              if (hold_left == 4'h1) begin
                dir_state <= DIR_IDLE;
              end
            end
          end
        end
        default: dir_state <= DIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_direction_output_o <= 1'b0;
    end else begin
      line_direction_output_o <= half_duplex_line_enable && !chan_reset_i &&
        ((dir_state == DIR_IDLE && tx_stat_i.pre_stop) ||
         (dir_state == DIR_SEND && !(both_empty && delay_bits == 4'h0 &&
          !tx_stat_i.thr_write && !tx_stat_i.pre_stop)) ||
         (dir_state == DIR_HOLD &&
          !(baud16_tick_i && hold_tick == `URIC_BIT_LAST && hold_left == 4'h1 &&
            both_empty && !tx_stat_i.thr_write && !tx_stat_i.pre_stop)));
    end
  end

  // ----------------------------------------------------------------
  // Transmit interrupt timing
  // ----------------------------------------------------------------
  logic prev_tsr_empty;
  logic prev_fifo_empty;
  logic prev_above;
  logic seen_above;
  logic tsr_rose;
  logic thr_rose;
  logic thresh_cross;

  assign tsr_rose = tx_stat_i.tsr_empty && !prev_tsr_empty;
  assign thr_rose = tx_stat_i.fifo_empty && !prev_fifo_empty;
  assign thresh_cross = prev_above && !tx_stat_i.above_thresh;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_tsr_empty <= 1'b1;
      prev_fifo_empty <= 1'b1;
      prev_above <= 1'b0;
      seen_above <= 1'b0;
    end else begin
      prev_tsr_empty <= tx_stat_i.tsr_empty;
      prev_fifo_empty <= tx_stat_i.fifo_empty;
      prev_above <= tx_stat_i.above_thresh;
      // Level above threshold is remembered until the holding side drains
      seen_above <= tx_stat_i.above_thresh || (seen_above && !thr_rose);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_o <= 1'b0;
    end else if (half_duplex_line_enable && !large_block_transmit) begin
      tx_irq_o <= tsr_rose;
    end else begin
      tx_irq_o <= thresh_cross || (thr_rose && !seen_above);
    end
  end

  // ----------------------------------------------------------------
  // Infrared path and pin routing
  // ----------------------------------------------------------------
  logic ir_tx;
  logic ir_rx;

  uric_ir_enc u_enc (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(baud16_tick_i),
    .tx_data_i(tx_serial_i),
    .ir_o(ir_tx)
  );

  uric_ir_dec u_dec (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(baud16_tick_i),
    .rx_i(rx_sync),
    .data_o(ir_rx)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_o <= 1'b1;
      rx_serial_o <= 1'b1;
    end else if (loopback_select_bit) begin
      tx_pin_o <= !infrared_mode_enable;
      rx_serial_o <= tx_serial_i;
    end else begin
      tx_pin_o <= infrared_mode_enable ? ir_tx : tx_serial_i;
      rx_serial_o <= infrared_mode_enable ? ir_rx : rx_sync;
    end
  end

  // ----------------------------------------------------------------
  // Receive storage and interrupt gating
  // ----------------------------------------------------------------
  logic rx_keep;

  assign rx_keep = loopback_select_bit || receiver_listen_enable ||
                   !(half_duplex_line_enable || infrared_mode_enable);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_store_o <= 1'b0;
      rx_irq_allow_o <= 1'b0;
      rx_timeout_allow_o <= 1'b0;
    end else begin
      rx_store_o <= rx_char_valid_i && rx_keep;
      rx_irq_allow_o <= rx_keep;
      rx_timeout_allow_o <= receiver_listen_enable;
    end
  end

  // ----------------------------------------------------------------
  // Mid-bit sampling strobe
  // ----------------------------------------------------------------
  logic samp_busy;
  logic samp_prev;
  logic [3:0] samp_tick;
  logic [7:0] samp_left;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      samp_busy <= 1'b0;
      samp_prev <= 1'b1;
      samp_tick <= 4'h0;
      samp_left <= 8'h00;
      rx_sample_o <= 1'b0;
      rx_sample_bit_o <= 1'b1;
    end else begin
      samp_prev <= rx_serial_o;
      rx_sample_o <= 1'b0;
      if (!samp_busy) begin
        if (samp_prev && !rx_serial_o) begin
          samp_busy <= 1'b1;
          samp_tick <= 4'h0;
          samp_left <= 8'(FRAME_BITS);
        end
      end else if (baud16_tick_i) begin
        samp_tick <= samp_tick + 4'h1;
        if (samp_tick + 4'h1 == `URIC_SAMPLE_TICK) begin
          rx_sample_o <= 1'b1;
          rx_sample_bit_o <= rx_serial_o;
          samp_left <= samp_left - 8'h01;
          if (samp_left == 8'h01) begin
            samp_busy <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  dir_off_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !half_duplex_line_enable |=> !line_direction_output_o) else $error("direction high off mode");
  dir_rise_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    half_duplex_line_enable && !chan_reset_i && tx_stat_i.pre_stop |=> line_direction_output_o)
    else $error("direction did not rise");
  dir_pending_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    line_direction_output_o && !both_empty && half_duplex_line_enable && !chan_reset_i
    |=> line_direction_output_o) else $error("direction dropped with data pending");
  dly_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    dir_state == DIR_SEND && both_empty && delay_bits != 4'h0 && half_duplex_line_enable &&
    !chan_reset_i && !tx_stat_i.thr_write && !tx_stat_i.pre_stop
    |=> dir_state == DIR_HOLD && hold_left == $past(delay_bits)) else $error("delay not armed");
  dly_cancel_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    dir_state == DIR_HOLD && tx_stat_i.thr_write && half_duplex_line_enable && !chan_reset_i
    |=> dir_state == DIR_SEND && line_direction_output_o) else $error("delay not cancelled");
  dly_end_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    dir_state == DIR_HOLD && baud16_tick_i && hold_tick == `URIC_BIT_LAST && hold_left == 4'h1
    && both_empty && !tx_stat_i.thr_write && !tx_stat_i.pre_stop
    |=> !line_direction_output_o && dir_state == DIR_IDLE) else $error("delay did not end");
  irq_tsr_only_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    half_duplex_line_enable && !large_block_transmit |=> tx_irq_o == $past(tsr_rose))
    else $error("tx interrupt off shift-empty");
  irq_cross_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    large_block_transmit && thresh_cross |=> tx_irq_o) else $error("threshold crossing lost");
  rx_block_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_char_valid_i && !loopback_select_bit && !receiver_listen_enable &&
    (half_duplex_line_enable || infrared_mode_enable) |=> !rx_store_o)
    else $error("data stored while blocked");
  rx_timeout_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !receiver_listen_enable |=> !rx_timeout_allow_o) else $error("timeout offered without listen");
  loop_pins_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    loopback_select_bit |=> tx_pin_o == !$past(infrared_mode_enable))
    else $error("tx pin active in loopback");

  dir_hold_cover: cover property (@(posedge clk_i) disable iff (!rst_n)
    dir_state == DIR_HOLD ##1 dir_state == DIR_IDLE);
  dly_cancel_cover: cover property (@(posedge clk_i) disable iff (!rst_n)
    dir_state == DIR_HOLD && tx_stat_i.thr_write);
  sample_cover: cover property (@(posedge clk_i) disable iff (!rst_n) rx_sample_o);
  irq_cover: cover property (@(posedge clk_i) disable iff (!rst_n) tx_irq_o);
endmodule
`default_nettype wire

// ---- rtl/uric_regs.svh ----
// Register offsets, field positions, reset values and tick counts of the line-mode block
`ifndef URIC_REGS_SVH
`define URIC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define URIC_ADDR_W 4
`define URIC_DATA_W 8
`define URIC_AFC_OFS 4'h0
`define URIC_LOOP_OFS 4'h1
`define URIC_STAT_OFS 4'h2

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define URIC_AFC_DLY_MSB 7
`define URIC_AFC_DLY_LSB 5
`define URIC_AFC_RCV 4
`define URIC_AFC_LG 3
`define URIC_AFC_HD 2
`define URIC_AFC_IR 1
`define URIC_AFC_WMASK 8'hfe
`define URIC_AFC_RST 8'h00
`define URIC_LOOP_BIT 0
`define URIC_LOOP_RST 1'b0

// ----------------------------------------------------------------
// Timing in 16x ticks, frame length in bits
// ----------------------------------------------------------------
`define URIC_BIT_LAST 4'hf
`define URIC_IR_RISE_TICK 4'h7
`define URIC_IR_FALL_TICK 4'ha
`define URIC_SAMPLE_TICK 4'h8
`define URIC_FRAME_BITS 10

`endif

// ---- rtl/uric_pkg.sv ----
// Types shared by the line-mode block
package uric_pkg;
  `include "uric_regs.svh"

  typedef struct packed {
    logic [`URIC_ADDR_W-1:0] addr;
    logic [`URIC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } uric_bus_req_type;

  typedef struct packed {
    logic tsr_empty;
    logic fifo_empty;
    logic above_thresh;
    logic thr_write;
    logic pre_stop;
  } uric_tx_stat_type;

  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_SEND = 2'b01,
    DIR_HOLD = 2'b10
  } uric_dir_state_type;
endpackage

// ---- rtl/uric_ir_enc.sv ----
// Infrared pulse encoder driven by the 16x tick
`timescale 1ns/1ps
`default_nettype none
`include "uric_regs.svh"
module uric_ir_enc
  import uric_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timing and data
  input wire logic tick_i,
  input wire logic tx_data_i,
  // Pulse out
  output logic ir_o
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  assign next_cnt = cnt + 4'h1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      ir_o <= 1'b0;
    end else if (tx_data_i) begin
      cnt <= 4'h0;
      ir_o <= 1'b0;
    end else if (tick_i) begin
      cnt <= next_cnt;
      if (next_cnt == `URIC_IR_RISE_TICK) begin
        ir_o <= 1'b1;
      end else if (next_cnt == `URIC_IR_FALL_TICK) begin
        ir_o <= 1'b0;
      end
    end
  end

  enc_idle_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_data_i |=> !ir_o) else $error("encoder drives while data high");
  enc_pulse_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ir_o) |-> cnt == `URIC_IR_RISE_TICK) else $error("pulse starts off tick seven");
  enc_pulse_cover: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(ir_o));
endmodule
`default_nettype wire

// ---- rtl/uric_ir_dec.sv ----
// Infrared pulse decoder: each falling edge yields a 16-tick low
`timescale 1ns/1ps
`default_nettype none
`include "uric_regs.svh"
module uric_ir_dec
  import uric_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timing and synchronised line
  input wire logic tick_i,
  input wire logic rx_i,
  // Decoded data
  output logic data_o
);
  logic rx_prev;
  logic pend;
  logic fall;
  logic [3:0] cnt;

  // Falling edge serves both pulse senses: positive pulses end on it
  assign fall = rx_prev && !rx_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_prev <= 1'b1;
      pend <= 1'b0;
    end else begin
      rx_prev <= rx_i;
      // An edge taken on a tick is consumed there, so the low is not restarted
      pend <= (fall || pend) && !tick_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 1'b1;
      cnt <= 4'h0;
    end else if (tick_i && (pend || fall)) begin
      data_o <= 1'b0;
      cnt <= 4'h0;
    end else if (tick_i && !data_o) begin
      cnt <= cnt + 4'h1;
      if (cnt == `URIC_BIT_LAST) begin
        data_o <= 1'b1;
      end
    end
  end

  dec_fall_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_i && (pend || fall) |=> !data_o) else $error("decoder missed an edge");
  dec_quiet_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    data_o && !fall && !pend |=> data_o) else $error("decoder fell without edge");
endmodule
`default_nettype wire

// ---- verification/uric_line_model.sv ----
// Behavioural RS-485 transceiver and infrared LED/detector facing the channel pins
`timescale 1ns/1ps
`default_nettype none
module uric_line_model (
  // Channel pins and bench mode select
  input wire logic tx_i,
  input wire logic dir_i,
  input wire logic ir_i,
  input wire logic inv_i,
  // Receive pin back to the channel
  output logic rx_o
);
  // Detector gives low or high pulses; an undriven bus rests high on its bias
  assign rx_o = ir_i ? (inv_i ? ~tx_i : tx_i) : (dir_i ? tx_i : 1'b1);
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench of the line-mode block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uric_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t value mismatch", $time); end end
  logic clk = 0, rst_n = 0, tick = 0, tx_ser = 1, rx_valid = 0, ir_mode = 0, inv = 1, chan_rst = 0;
  uric_bus_req_type bus = '0;
  uric_tx_stat_type stat = '0;
  logic [7:0] rdata, d, q;
  logic rx_ser, store, irq_ok, tmo_ok, smp, smp_bit, tx_pin, dir, tx_irq, rx_pin, k, sbit;
  int mismatches = 0, check_count = 0, n, c, e, hi, lo, first, s;
  always #4 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  uric_top dut (.clk_i(clk), .rst_n_i(rst_n), .chan_reset_i(chan_rst), .bus_i(bus),
    .rdata_o(rdata), .baud16_tick_i(tick), .tx_stat_i(stat), .tx_serial_i(tx_ser),
    .tx_irq_o(tx_irq), .rx_char_valid_i(rx_valid), .rx_serial_o(rx_ser), .rx_store_o(store),
    .rx_irq_allow_o(irq_ok), .rx_timeout_allow_o(tmo_ok), .rx_sample_o(smp),
    .rx_sample_bit_o(smp_bit), .rx_pin_i(rx_pin), .tx_pin_o(tx_pin),
    .line_direction_output_o(dir));
  uric_line_model far (.tx_i(tx_pin), .dir_i(dir), .ir_i(ir_mode), .inv_i(inv), .rx_o(rx_pin));
  // ----------------------------------------------------------------
  // Bus cycles and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  function automatic int dly(input logic [2:0] f);
    return (f == 3'h0) ? 0 : 2 * f + 1;
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300us;
    mismatches++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(44));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK(rx_ser, 1'b1)
    `CHK(dir, 1'b0)
    rd(4'h0, d); `CHK(d, 8'h00)
    rd(4'h9, d); `CHK(d, 8'h00)
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      k = i[3] | i[2] | ~(i[1] | i[0]);
      d = {3'($urandom), i[2], 1'b0, i[1], i[0], 1'b0};
      wr(4'h1, {7'h00, i[3]});
      wr(4'h0, d | 8'h01);
      rd(4'h0, q); `CHK(q, d)
      @(posedge clk) rx_valid <= 1'b1;
      @(posedge clk) rx_valid <= 1'b0;
      #1 `CHK(store, k)
      `CHK(irq_ok, k)
      `CHK(tmo_ok, i[2])
    end
    wr(4'h1, 8'h00);
    $display("test receive gating done");
    for (int f = 0; f < 8; f++) begin
      wr(4'h0, {f[2:0], 5'b00100});
      @(posedge clk) stat <= '0;
      @(posedge clk) stat.pre_stop <= 1'b1;
      @(posedge clk) stat.pre_stop <= 1'b0;
      #1 `CHK(dir, 1'b1)
      repeat (20) @(posedge clk);
      #1 `CHK(dir, 1'b1)
      @(posedge clk) stat <= 5'b11000;
      n = 0;
      c = (f == 7) ? 100 : 0;
      while (n < 900) begin
        @(posedge clk) stat.thr_write <= (n == c && c > 0);
        #1 n++;
        if (n == 1) `CHK(tx_irq, 1'b1)
        if (dir !== 1'b1) break;
      end
      e = dly(f[2:0]) * 32 + c;
      `CHK(n >= e - 3 && n <= e + 4, 1'b1)
    end
    // Status during a running delay, then a channel reset cuts it short
    wr(4'h0, 8'he4);
    @(posedge clk) stat <= '0;
    @(posedge clk) stat.pre_stop <= 1'b1;
    @(posedge clk) stat <= 5'b11000;
    repeat (4) @(posedge clk);
    rd(4'h2, d); `CHK(d, 8'h0f)
    @(posedge clk) chan_rst <= 1'b1;
    @(posedge clk) chan_rst <= 1'b0;
    #1 `CHK(dir, 1'b0)
    rd(4'h2, d); `CHK(d, 8'h0c)
    $display("test direction done");
    wr(4'h0, 8'h0c);
    @(posedge clk) stat.above_thresh <= 1'b1;
    repeat (3) @(posedge clk);
    stat.above_thresh <= 1'b0;
    @(posedge clk);
    #1 `CHK(tx_irq, 1'b1)
    // First drain after a threshold excursion is silent, the next one interrupts
    @(posedge clk) stat.fifo_empty <= 1'b0;
    @(posedge clk) stat.fifo_empty <= 1'b1;
    @(posedge clk);
    #1 `CHK(tx_irq, 1'b0)
    @(posedge clk) stat.fifo_empty <= 1'b0;
    @(posedge clk) stat.fifo_empty <= 1'b1;
    @(posedge clk);
    #1 `CHK(tx_irq, 1'b1)
    $display("test large block done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) ir_mode <= 1'b1;
      inv <= (p == 0);
      wr(4'h0, 8'h12);
      repeat (400) @(posedge clk);
      {hi, lo, first, s, sbit} = {32'd0, 32'd0, -32'sd1, -32'sd1, 1'bx};
      for (n = 0; n < 120; n++) begin
        @(posedge clk) tx_ser <= (n >= 32);
        #1 hi += tx_pin;
        lo += !rx_ser;
        if (!rx_ser && first < 0) first = n;
        if (n == s + 1 && s >= 0) sbit = smp_bit;
        if (smp === 1'b1 && s < 0) s = n;
      end
      `CHK(hi == 6, 1'b1)
      `CHK(lo == 32, 1'b1)
      `CHK(s - first >= 14 && s - first <= 18, 1'b1)
      `CHK(sbit, 1'b0)
    end
    $display("test infrared done");
    print_verdict;
  end
endmodule
`default_nettype wire
